// ===== pkg/cca_pkg.sv
// Purpose: shared constants and carrier types of the counter array
// Assumes: byte-wide special-function register access, 8-bit addresses
// Notes:   one package serves both the array top and its channel modules
package cca_pkg;

    localparam int NUM_CHANNELS = 3;
    localparam int WIDE_BITS    = 10;
    localparam int STATUS_BITS  = 4;

    // register addresses
    localparam logic [7:0] ADDR_PRESC0  = 8'hFB;
    localparam logic [7:0] ADDR_PRESC1  = 8'hFC;
    localparam logic [7:0] ADDR_CFG0    = 8'hA4;
    localparam logic [7:0] ADDR_CFG1    = 8'hBC;
    localparam logic [7:0] ADDR_STATUS  = 8'hA5;
    localparam logic [7:0] ADDR_BASE0   = 8'hD8;
    localparam logic [7:0] ADDR_BASE1   = 8'hE8;
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_CAPL     = 8'h03;
    localparam logic [7:0] OFS_CAPH     = 8'h06;
    localparam logic [7:0] OFS_FREQ     = 8'h09;
    localparam logic [7:0] OFS_CNTL     = 8'h0A;
    localparam logic [7:0] OFS_CNTH     = 8'h0B;

    // field positions, masks and reset values
    localparam logic [7:0] PRESC_RESET   = 8'h10;
    localparam logic [7:0] PRESC_WMASK   = 8'h1F;
    localparam int         PRESC_CE_BIT  = 4;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] CFG_WMASK     = 8'h77;
    localparam int         CFG_EN_BIT    = 6;
    localparam int         CFG_OVFIE_BIT = 5;
    localparam int         CFG_IDLE_BIT  = 4;
    localparam int         CFG_WIDE_BIT  = 2;
    localparam logic [7:0] MODE_RESET    = 8'h00;

    // clock source select codes
    localparam logic [1:0] CLKSEL_PRESC  = 2'b00;
    localparam logic [1:0] CLKSEL_TIMER0 = 2'b01;
    localparam logic [1:0] CLKSEL_EXTPIN = 2'b10;

    // channel waveform field codes
    localparam logic [1:0] PWM_OFF    = 2'b00;
    localparam logic [1:0] PWM_FIXED8 = 2'b01;
    localparam logic [1:0] PWM_PROG8  = 2'b10;
    localparam logic [1:0] PWM_WIDE   = 2'b11;

    typedef struct packed {
        logic       eintf;
        logic       ecomp;
        logic       capPe;
        logic       capNe;
        logic       match;
        logic       toggle;
        logic [1:0] pwm;
    } cca_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cca_sfr_t;

endpackage

// ===== rtl/cca_channel_module.sv
// Purpose: one channel module: capture, timer, toggle and PWM waveforms
// Assumes: count, step and freqLoad come from flops of the array top
// Notes:   pin input is synchronous to clock; output is registered
`timescale 1ns/10ps
module cca_channel_module (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              wrMode,
    input  wire logic              wrLow,
    input  wire logic              wrHigh,
    input  wire logic [7:0]        wdata,
    input  wire logic [15:0]       count,
    input  wire logic              step,
    input  wire logic              freqLoad,
    input  wire logic              wide10,
    input  wire logic              pinIn,
    output cca_pkg::cca_mode_t     mode,
    output logic [7:0]             capLow,
    output logic [7:0]             capHigh,
    output logic                   chanEvent,
    output logic                   chanOut,
    output logic                   drivesPin
);
    import cca_pkg::*;

    typedef struct packed {
        cca_mode_t  mode;
        logic [7:0] capLow;
        logic [7:0] capHigh;
        logic       pinPrev;
        logic       out;
        logic       evt;
    } cca_chan_state_t;

    cca_chan_state_t state;
    cca_chan_state_t next_state;
    logic [15:0]     cap16;
    logic            hit;
    logic            capturing;

    always_comb begin
        next_state = state;
        next_state.evt = 1'b0;
        next_state.pinPrev = pinIn;
        cap16 = {state.capHigh, state.capLow};
        hit = step && state.mode.ecomp && (count == cap16); // RQ9
        capturing = (state.mode.pwm == PWM_OFF)
            && ((state.mode.capPe && pinIn && !state.pinPrev)
            || (state.mode.capNe && !pinIn && state.pinPrev));
        if (wrMode) begin
            next_state.mode = cca_mode_t'(wdata);
        end
        if (wrLow) begin
            next_state.capLow = wdata;
            next_state.mode.ecomp = 1'b0; // RQ21
        end
        if (wrHigh) begin
            next_state.capHigh = wdata;
            next_state.mode.ecomp = 1'b1; // RQ21
        end
        case (state.mode.pwm)
            PWM_FIXED8: begin
                // low-byte wrap starts a new pulse with the buffered duty
                if (step && count[7:0] == 8'h00) begin
                    next_state.capLow = state.capHigh; // RQ13 RQ11
                end
                next_state.out = state.mode.ecomp
                    && (count[7:0] >= state.capLow); // RQ12 RQ22
            end
            PWM_PROG8: begin
                if (freqLoad) begin
                    next_state.capLow = state.capHigh; // RQ14
                end
                next_state.out = state.mode.ecomp
                    && (count[7:0] >= state.capLow); // RQ12
            end
            PWM_WIDE: begin
                // upper six bits are ignored in the 10-bit variant
                next_state.out = state.mode.ecomp && (wide10
                    ? (count[WIDE_BITS-1:0] >= cap16[WIDE_BITS-1:0])
                    : (count >= cap16)); // RQ17 RQ19 RQ22
            end
            default: begin
                if (capturing) begin
                    next_state.capHigh = count[15:8]; // RQ8
                    next_state.capLow = count[7:0];
                    next_state.evt = 1'b1; // RQ7
                end
                if (hit && state.mode.match) begin
                    next_state.evt = 1'b1; // RQ7 RQ9
                end
                if (hit && state.mode.toggle) begin
                    next_state.out = !state.out; // RQ10
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign mode      = state.mode;
    assign capLow    = state.capLow;
    assign capHigh   = state.capHigh;
    assign chanEvent = state.evt;
    assign chanOut   = state.out;
    assign drivesPin = (state.mode.pwm != PWM_OFF) || state.mode.toggle;

    AST_PWM_QUIET: assert property (@(posedge clock) disable iff (!resetn)
        (state.mode.pwm != PWM_OFF) |=> !chanEvent) // RQ7
        else $error("event raised in a PWM mode");

    AST_ECOMP_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        (wrLow && !wrHigh) |=> !mode.ecomp) // RQ21
        else $error("low compare write left comparator enabled");

    AST_CAPTURE_LOAD: assert property (@(posedge clock)
        disable iff (!resetn)
        (capturing && !wrLow && !wrHigh)
        |=> ({capHigh, capLow} == $past(count)) && chanEvent) // RQ8
        else $error("capture did not load the counter value");

    AST_TOGGLE_FLIP: assert property (@(posedge clock) disable iff (!resetn)
        (hit && state.mode.toggle && state.mode.pwm == PWM_OFF)
        |=> (chanOut != $past(chanOut))) // RQ10
        else $error("toggle match did not invert the output");

endmodule

// ===== rtl/cca_counter_array.sv
// Purpose: counter array with shared 16-bit counter and three channels
// Assumes: byte register port, single clock, pins synchronous to clock
// Notes:   ARRAY_INDEX picks which register addresses this copy answers
//
// Behaviour
// [RQ1] free-running 16-bit up-counter wraps; programmable-frequency PWM clears it
// [RQ2] counter clock is prescaler, timer 0 overflow or external pin
// [RQ3] external clock pin must stay at or below a quarter of clock
// [RQ4] prescaled clock divides clock by two to the four-bit field
// [RQ5] prescaler register holds clock enable, reset value hex 10
// [RQ6] three channels share the counter, pins are plain I/O otherwise
// [RQ7] capture, timer and toggle raise events; PWM never does
// [RQ8] capture copies counter on rising, falling or either pin edge
// [RQ9] timer mode compares written 16-bit value with counter on equality
// [RQ10] toggle mode inverts channel output on each enabled compare match
// [RQ11] fixed 8-bit PWM period is the counter low byte wrap
// [RQ12] 8-bit PWM output high while low byte at or above duty
// [RQ13] on low byte wrap the high compare byte reloads the low
// [RQ14] programmable PWM clears counter on frequency match and reloads registers
// [RQ15] software keeps other channels in programmable mode or unused
// [RQ16] software keeps frequency value above every channel duty
// [RQ17] 16-bit PWM high at or above compare, low at overflow
// [RQ18] software sets all three channels to 10-bit PWM together
// [RQ19] 10-bit PWM ignores upper six bits and wraps at 10 bits
// [RQ20] software writes the low compare byte before the high byte
// [RQ21] low compare write clears comparator enable, high write sets it
// [RQ22] compare zero is full on; disabled comparator gives constant low
// [RQ23] clock select 00 prescaler, 01 timer 0, 10 external pin
// [RQ24] match or capture sets a sticky flag; flags form one request
// [RQ25] waveform field 01 fixed, 10 programmable 8-bit PWM on pin
// [RQ26] timer 0 overflow and external clock synchronised, counted per rise
`timescale 1ns/10ps
module cca_counter_array #(
    parameter int unsigned ARRAY_INDEX = 0
) (
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire cca_pkg::cca_sfr_t        sfr,
    output logic [7:0]                    sfrRdata,
    input  wire logic                     cpuIdle,
    input  wire logic                     timer0Overflow,
    input  wire logic                     extClockPin,
    input  wire logic [2:0]               chanPinIn,
    input  wire logic [2:0]               gpioOut,
    input  wire logic [2:0]               gpioOe,
    output logic [2:0]                    chanPinOut,
    output logic [2:0]                    chanPinOe,
    output logic                          irq
);
    import cca_pkg::*;

    if (ARRAY_INDEX > 1) begin : g_badIndex
        $error("ARRAY_INDEX must be 0 or 1");
    end

    localparam logic [7:0] PRESC_ADDR =
        (ARRAY_INDEX == 0) ? ADDR_PRESC0 : ADDR_PRESC1;
    localparam logic [7:0] CFG_ADDR =
        (ARRAY_INDEX == 0) ? ADDR_CFG0 : ADDR_CFG1;
    localparam logic [7:0] BASE =
        (ARRAY_INDEX == 0) ? ADDR_BASE0 : ADDR_BASE1;
    localparam int STATUS_LSB = ARRAY_INDEX * STATUS_BITS;

    typedef struct packed {
        logic [7:0]  presc;
        logic [7:0]  cfg;
        logic [7:0]  freqBuf;
        logic [7:0]  freqActive;
        logic [15:0] count;
        logic [14:0] divider;
        logic [3:0]  status;
        logic [2:0]  t0Sync;
        logic [2:0]  extSync;
        logic        step;
        logic        freqLoad;
        logic [7:0]  rdata;
    } cca_array_state_t;

    cca_array_state_t state;
    cca_array_state_t next_state;

    // decodes a register address as base plus offset
    function automatic logic isReg(input logic [7:0] addr,
                                   input logic [7:0] ofs);
        return addr == 8'(BASE + ofs);
    endfunction

    // prescaler tick when the low 'ps' divider bits are all zero
    function automatic logic prescHit(input logic [14:0] div,
                                      input logic [3:0]  ps);
        logic [14:0] mask;
        mask = 15'(~(16'hFFFF << ps));
        return (div & mask) == 15'h0000;
    endfunction

    cca_mode_t  chMode  [NUM_CHANNELS];
    logic [7:0] chLow   [NUM_CHANNELS];
    logic [7:0] chHigh  [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] chEvent;
    logic [NUM_CHANNELS-1:0] chOut;
    logic [NUM_CHANNELS-1:0] chDrives;
    logic [NUM_CHANNELS-1:0] wrMode;
    logic [NUM_CHANNELS-1:0] wrLow;
    logic [NUM_CHANNELS-1:0] wrHigh;
    logic [NUM_CHANNELS-1:0] eintfBits;

    logic       run;
    logic       t0Rise;
    logic       extRise;
    logic       prescTick;
    logic       tick;
    logic       pfMode;
    logic       pfHit;
    logic       wrap;
    logic       wide10;
    logic [1:0] clkSel;
    logic [7:0] readMux;

    always_comb begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            wrMode[i] = sfr.wr && isReg(sfr.addr, 8'(OFS_MODE + 8'(i)));
            wrLow[i]  = sfr.wr && isReg(sfr.addr, 8'(OFS_CAPL + 8'(i)));
            wrHigh[i] = sfr.wr && isReg(sfr.addr, 8'(OFS_CAPH + 8'(i)));
            eintfBits[i] = chMode[i].eintf;
        end
    end

    for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
        cca_channel_module u_chan (
            .clock     (clock),
            .resetn    (resetn),
            .wrMode    (wrMode[g]),
            .wrLow     (wrLow[g]),
            .wrHigh    (wrHigh[g]),
            .wdata     (sfr.wdata),
            .count     (state.count),
            .step      (state.step),
            .freqLoad  (state.freqLoad),
            .wide10    (wide10),
            .pinIn     (chanPinIn[g]),
            .mode      (chMode[g]),
            .capLow    (chLow[g]),
            .capHigh   (chHigh[g]),
            .chanEvent (chEvent[g]),
            .chanOut   (chOut[g]),
            .drivesPin (chDrives[g])
        );
    end

    always_comb begin
        next_state = state;
        wide10 = state.cfg[CFG_WIDE_BIT];
        clkSel = state.cfg[1:0];
        // only the second and third sync stages feed the edge test
        t0Rise  = state.t0Sync[1] && !state.t0Sync[2]; // RQ26
        extRise = state.extSync[1] && !state.extSync[2]; // RQ26
        next_state.t0Sync  = {state.t0Sync[1:0], timer0Overflow};
        next_state.extSync = {state.extSync[1:0], extClockPin};

        // divider only runs while its clock enable is set
        if (state.presc[PRESC_CE_BIT]) begin
            next_state.divider = state.divider + 15'h0001; // RQ5
        end else begin
            next_state.divider = 15'h0000;
        end
        prescTick = state.presc[PRESC_CE_BIT]
            && prescHit(state.divider, state.presc[3:0]); // RQ4

        run = state.cfg[CFG_EN_BIT]
            && !(state.cfg[CFG_IDLE_BIT] && cpuIdle);
        case (clkSel)
            CLKSEL_PRESC:  tick = run && prescTick; // RQ23 RQ2
            CLKSEL_TIMER0: tick = run && t0Rise; // RQ23 RQ2
            CLKSEL_EXTPIN: tick = run && extRise; // RQ23 RQ2
            default:       tick = 1'b0;
        endcase

        pfMode = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            pfMode = pfMode || (chMode[i].pwm == PWM_PROG8); // RQ25
        end
        pfHit = tick && pfMode
            && (state.count[7:0] == state.freqActive); // RQ14

        wrap = 1'b0;
        if (pfHit) begin
            next_state.count = 16'h0000; // RQ14 RQ1
        end else if (tick && wide10) begin
            wrap = state.count[WIDE_BITS-1:0] == 10'h3FF; // RQ19
            next_state.count = {6'h00,
                10'(state.count[WIDE_BITS-1:0] + 10'h001)};
        end else if (tick) begin
            wrap = state.count == 16'hFFFF; // RQ1
            next_state.count = state.count + 16'h0001;
        end
        next_state.step = tick;
        next_state.freqLoad = pfHit;

        // frequency buffer goes live at each period end
        if (pfHit || !pfMode) begin
            next_state.freqActive = state.freqBuf; // RQ14
        end

        if (sfr.wr) begin
            if (sfr.addr == PRESC_ADDR) begin
                next_state.presc = sfr.wdata & PRESC_WMASK;
            end
            if (sfr.addr == CFG_ADDR) begin
                next_state.cfg = sfr.wdata & CFG_WMASK;
            end
            if (isReg(sfr.addr, OFS_FREQ)) begin
                next_state.freqBuf = sfr.wdata;
            end
            if (isReg(sfr.addr, OFS_CNTL)) begin
                next_state.count[7:0] = sfr.wdata;
            end
            if (isReg(sfr.addr, OFS_CNTH)) begin
                next_state.count[15:8] = sfr.wdata;
            end
            if (sfr.addr == ADDR_STATUS) begin
                next_state.status = sfr.wdata[STATUS_LSB +: STATUS_BITS];
            end
        end
        // hardware set wins over a clearing write in the same cycle
        next_state.status = next_state.status | {wrap, chEvent}; // RQ24

        readMux = 8'h00;
        if (sfr.addr == PRESC_ADDR) begin
            readMux = state.presc;
        end else if (sfr.addr == CFG_ADDR) begin
            readMux = state.cfg;
        end else if (sfr.addr == ADDR_STATUS) begin
            readMux[STATUS_LSB +: STATUS_BITS] = state.status;
        end else if (isReg(sfr.addr, OFS_FREQ)) begin
            readMux = state.freqBuf;
        end else if (isReg(sfr.addr, OFS_CNTL)) begin
            readMux = state.count[7:0];
        end else if (isReg(sfr.addr, OFS_CNTH)) begin
            readMux = state.count[15:8];
        end
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (isReg(sfr.addr, 8'(OFS_MODE + 8'(i)))) begin
                readMux = chMode[i];
            end
            if (isReg(sfr.addr, 8'(OFS_CAPL + 8'(i)))) begin
                readMux = chLow[i];
            end
            if (isReg(sfr.addr, 8'(OFS_CAPH + 8'(i)))) begin
                readMux = chHigh[i];
            end
        end
        next_state.rdata = sfr.rd ? readMux : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
            state.presc <= PRESC_RESET; // RQ5
            state.cfg <= CFG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // unassigned pins fall back to plain port I/O
    always_comb begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            chanPinOut[i] = chDrives[i] ? chOut[i] : gpioOut[i]; // RQ6
            chanPinOe[i]  = chDrives[i] || gpioOe[i]; // RQ6
        end
    end

    assign irq = (|(state.status[2:0] & eintfBits))
        || (state.status[3] && state.cfg[CFG_OVFIE_BIT]); // RQ24
    assign sfrRdata = state.rdata;

    AST_PRESC_RESET: assert property (@(posedge clock)
        !resetn |=> (state.presc == PRESC_RESET)) // RQ5
        else $error("prescaler register reset value wrong");

    AST_COUNT_STEP: assert property (@(posedge clock) disable iff (!resetn)
        (tick && !pfHit && !wide10 && !sfr.wr)
        |=> (state.count == 16'($past(state.count) + 16'h0001))) // RQ1
        else $error("counter did not advance by one on a tick");

    AST_FREQ_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        (pfHit && !sfr.wr)
        |=> (state.count == 16'h0000) && state.freqLoad) // RQ14
        else $error("frequency match did not clear the counter");

    AST_EXT_SOURCE: assert property (@(posedge clock) disable iff (!resetn)
        (run && clkSel == CLKSEL_EXTPIN && extRise) |-> tick) // RQ23
        else $error("external pin rise not counted");

    AST_STOPPED: assert property (@(posedge clock) disable iff (!resetn)
        !state.cfg[CFG_EN_BIT] |-> !tick) // RQ2
        else $error("counter ticked while disabled");

    AST_FULL_RATE: assert property (@(posedge clock) disable iff (!resetn)
        (run && clkSel == CLKSEL_PRESC && state.presc[PRESC_CE_BIT]
        && state.presc[3:0] == 4'h0) |-> tick) // RQ4
        else $error("divide by one did not tick every cycle");

    // the edge test sees a pin rise exactly two edges after it is sampled
    AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!resetn)
        $rose(extClockPin) |-> ##2 extRise) // RQ26
        else $error("external pin rise not seen after the sync delay");

    // a clearing write one cycle after the set may legally drop the flag
    AST_FLAG_STICKY: assert property (@(posedge clock)
        disable iff (!resetn)
        (chEvent[0] ##1 !sfr.wr) |-> state.status[0] [*2]) // RQ24
        else $error("channel flag not set or not held");

    AST_IRQ_FLAG: assert property (@(posedge clock) disable iff (!resetn)
        (state.status[0] && chMode[0].eintf) |-> irq) // RQ24
        else $error("enabled flag did not raise the request");

    AST_WIDE_WRAP: assert property (@(posedge clock) disable iff (!resetn)
        (tick && wide10 && !pfHit && !sfr.wr
        && state.count[WIDE_BITS-1:0] == 10'h3FF)
        |=> (state.count == 16'h0000) && state.status[3]) // RQ19
        else $error("10-bit counter did not wrap to zero");

endmodule

// ===== tb/cca_far_model.sv
// Purpose: far side of the array: event pins and external counter clock
// Assumes: a pin whose enable is high reads back what the array drives
// Notes:   2 high + 2 low cycles per pulse keeps the rate at clock/4
`timescale 1ns/10ps
module cca_far_model (
    input  wire logic       clock,
    input  wire logic [2:0] chanPinOut,
    input  wire logic [2:0] chanPinOe,
    output logic [2:0]      chanPinIn,
    output logic            extClockPin
);
    logic [2:0] drive;
    initial begin
        drive = 3'h0;
        extClockPin = 1'b0;
    end
    assign chanPinIn = (chanPinOe & chanPinOut) | (~chanPinOe & drive);
    task automatic extPulses(input int n);
        repeat (n) begin
            @(posedge clock) extClockPin <= 1'b1;
            repeat (2) @(posedge clock);
            extClockPin <= 1'b0;
            @(posedge clock);
        end
    endtask
    task automatic setPin(input int idx, input logic val);
        @(posedge clock) drive[idx] <= val;
    endtask
endmodule

// ===== tb/cca_counter_array_test.sv
// Purpose: register-level self-checking bench of one counter array
// Assumes: counter stays stopped unless a test starts it
// Notes:   only the idle input is tied off
`timescale 1ns/10ps
module cca_counter_array_test;
    import cca_pkg::*;
    logic       clock;
    logic       resetn;
    cca_sfr_t   sfr;
    logic [7:0] sfrRdata;
    logic [2:0] chanPinIn;
    logic [2:0] chanPinOut;
    logic [2:0] chanPinOe;
    logic       extClockPin;
    logic       irq;
    logic       t0Ovf;
    logic [2:0] gpioOut;
    logic [2:0] gpioOe;
    int         ones;
    int         mismatches;
    int         cmp_count;
    int         cycles;

    cca_counter_array #(.ARRAY_INDEX(0)) i_dut (
        .clock(clock), .resetn(resetn), .sfr(sfr), .sfrRdata(sfrRdata),
        .cpuIdle(1'b0), .timer0Overflow(t0Ovf), .extClockPin(extClockPin),
        .chanPinIn(chanPinIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .irq(irq)
    );
    cca_far_model i_far (
        .clock(clock), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
        .chanPinIn(chanPinIn), .extClockPin(extClockPin)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hang counts as a failure and still reaches the verdict
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpBit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) begin
            sfr.addr <= a;
            sfr.wdata <= d;
            sfr.wr <= 1'b1;
        end
        @(posedge clock) sfr.wr <= 1'b0;
    endtask
    // read data is registered at the taking edge and stands one cycle
    task automatic rdCmp(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock) begin
            sfr.addr <= a;
            sfr.rd <= 1'b1;
        end
        @(posedge clock) sfr.rd <= 1'b0;
        #1 cmpByte(sfrRdata, exp);
    endtask
    task automatic settle;
        repeat (8) @(posedge clock);
        #1;
    endtask

    initial begin
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        ones = 0;
        t0Ovf = 1'b0;
        gpioOut = 3'h4;
        gpioOe = 3'h4;
        resetn = 1'b0;
        sfr = '0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rdCmp(8'hFB, 8'h10);
        rdCmp(8'h00, 8'h00);
        cmpBit(chanPinOut[2], 1'b1);
        cmpBit(chanPinOe[2], 1'b1);
        wrReg(8'hFB, 8'hFF);
        rdCmp(8'hFB, 8'h1F);
        $display("test registers done");
        wrReg(8'hD8, 8'hA0);
        wrReg(8'hE2, 8'h34);
        wrReg(8'hE3, 8'h12);
        i_far.setPin(0, 1'b1);
        settle();
        rdCmp(8'hDB, 8'h34);
        rdCmp(8'hDE, 8'h12);
        rdCmp(8'hA5, 8'h01);
        cmpBit(irq, 1'b1);
        wrReg(8'hA5, 8'h00);
        #1 cmpBit(irq, 1'b0);
        $display("test capture done");
        wrReg(8'hD8, 8'h4C);
        wrReg(8'hDB, 8'h07);
        rdCmp(8'hD8, 8'h0C);
        wrReg(8'hDE, 8'h00);
        rdCmp(8'hD8, 8'h4C);
        wrReg(8'hE2, 8'h05);
        wrReg(8'hE3, 8'h00);
        wrReg(8'hA4, 8'h42);
        i_far.extPulses(2);
        settle();
        cmpBit(chanPinOut[0], 1'b1);
        cmpBit(chanPinOe[0], 1'b1);
        rdCmp(8'hE2, 8'h07);
        rdCmp(8'hA4, 8'h42);
        wrReg(8'hA4, 8'h00);
        $display("test toggle done");
        wrReg(8'hA4, 8'h41);
        repeat (2) begin
            @(posedge clock) t0Ovf <= 1'b1;
            @(posedge clock) t0Ovf <= 1'b0;
        end
        settle();
        rdCmp(8'hE2, 8'h09);
        wrReg(8'hA4, 8'h00);
        $display("test timer 0 done");
        wrReg(8'hD9, 8'h41);
        wrReg(8'hDC, 8'h00);
        wrReg(8'hDF, 8'h00);
        settle();
        cmpBit(chanPinOut[1], 1'b1);
        wrReg(8'hDC, 8'h00);
        settle();
        cmpBit(chanPinOut[1], 1'b0);
        $display("test pwm done");
        // period is freq + 1 ticks, high while count is at or above duty
        wrReg(8'hD8, 8'h00);
        wrReg(8'hE1, 8'h04);
        wrReg(8'hE2, 8'h00);
        wrReg(8'hFB, 8'h10);
        wrReg(8'hD9, 8'h42);
        wrReg(8'hDC, 8'h02);
        wrReg(8'hDF, 8'h02);
        wrReg(8'hA4, 8'h40);
        settle();
        ones = 0;
        repeat (10) begin
            @(posedge clock);
            #1 ones = ones + chanPinOut[1];
        end
        cmpByte(8'(ones), 8'h06);
        wrReg(8'hA4, 8'h00);
        $display("test programmable pwm done");
        wrReg(8'hA5, 8'h00);
        wrReg(8'hD8, 8'h43);
        wrReg(8'hD9, 8'h43);
        wrReg(8'hDA, 8'h43);
        wrReg(8'hE2, 8'hFE);
        wrReg(8'hE3, 8'h03);
        wrReg(8'hA4, 8'h44);
        settle();
        cmpBit(chanPinOut[2], 1'b1);
        wrReg(8'hA4, 8'h00);
        rdCmp(8'hA5, 8'h08);
        rdCmp(8'hE3, 8'h00);
        $display("test wide pwm done");
        close_out();
    end
endmodule
